// ---- verilog/hdrbg_cfg.svh ----
`ifndef HDRBG_CFG_SVH
`define HDRBG_CFG_SVH
// ==========================================
// Timing and test constants
`define HDRBG_STUCK_LIMIT 16'h0020
`define HDRBG_WIN_BITS 16'h0400
`define HDRBG_ONES_LO 16'h0180
`define HDRBG_ONES_HI 16'h0280
`define HDRBG_SEED_BITS 8'h80
`define HDRBG_MIX_CONST 32'h9E3779B9
`define HDRBG_STATE_RESET 128'h0
`define HDRBG_FIFO_DEPTH 32
`endif

// ---- verilog/hdrbg_pkg.sv ----
package hdrbg_pkg;
	typedef enum logic [2:0] {
		HDRBG_IDLE,
		HDRBG_STARTUP,
		HDRBG_SEEDING,
		HDRBG_RUN,
		HDRBG_FAILED
	} hdrbg_state_e;
	typedef struct packed {
		logic stuck_fail;
		logic online_fail;
		logic startup_ok;
	} hdrbg_health_s;
endpackage

// ---- verilog/hdrbg_fifo_mem.sv ----
module hdrbg_fifo_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_r;
	logic [AW:0] rp_r;
	logic [AW:0] cnt;
	logic full;
	logic empty;
	logic do_wr;
	logic do_rd;
	// ==========================================
	// Pointers and flags
	assign cnt = wp_r - rp_r;
	assign full = cnt == (AW+1)'(DEPTH);
	assign empty = wp_r == rp_r;
	assign in_ready = !full && !flush;
	assign do_wr = ce && in_valid && in_ready;
	assign do_rd = ce && !flush && (!out_valid || out_ready) && !empty;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wp_r <= '0;
			rp_r <= '0;
			out_valid <= 1'b0;
		end else if (ce) begin
			if (flush) begin
				wp_r <= '0;
				rp_r <= '0;
				out_valid <= 1'b0;
			end else begin
				if (do_wr)
					wp_r <= wp_r + 1'b1;
				if (do_rd)
					rp_r <= rp_r + 1'b1;
				if (do_rd)
					out_valid <= 1'b1;
				else if (out_ready)
					out_valid <= 1'b0;
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (do_wr)
			mem[wp_r[AW-1:0]] <= in_data;
		if (do_rd)
			out_data <= mem[rp_r[AW-1:0]];
	end
endmodule // hdrbg_fifo_mem

// ---- verilog/hdrbg_health.sv ----
`include "hdrbg_cfg.svh"
module hdrbg_health (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic restart,
	input wire logic raw_valid,
	input wire logic raw_bit,
	output hdrbg_pkg::hdrbg_health_s health
);
	logic [15:0] run_r;
	logic [15:0] bits_r;
	logic [15:0] ones_r;
	logic prev_r;
	logic win_end;
	logic stuck_hit;
	logic ones_bad;
	logic [15:0] ones_nxt;
	// ==========================================
	// Repetition and window tests
	assign stuck_hit = raw_valid && raw_bit == prev_r
		&& run_r == `HDRBG_STUCK_LIMIT - 16'h0002;
	assign win_end = raw_valid && bits_r == `HDRBG_WIN_BITS - 16'h0001;
	assign ones_nxt = ones_r + {15'h0000, raw_bit};
	assign ones_bad = ones_nxt < `HDRBG_ONES_LO
		|| ones_nxt > `HDRBG_ONES_HI;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			run_r <= 16'h0000;
			bits_r <= 16'h0000;
			ones_r <= 16'h0000;
			prev_r <= 1'b0;
			health <= '0;
		end else if (ce) begin
			if (restart) begin
				run_r <= 16'h0000;
				bits_r <= 16'h0000;
				ones_r <= 16'h0000;
				health <= '0;
			end else if (raw_valid) begin
				prev_r <= raw_bit;
				run_r <= (raw_bit == prev_r) ? run_r + 16'h0001 : 16'h0000;
				if (stuck_hit)
					health.stuck_fail <= 1'b1;
				bits_r <= win_end ? 16'h0000 : bits_r + 16'h0001;
				ones_r <= win_end ? 16'h0000 : ones_nxt;
				if (win_end && ones_bad)
					health.online_fail <= 1'b1;
				if (win_end && !ones_bad)
					health.startup_ok <= 1'b1;
			end
		end
	end
endmodule // hdrbg_health

// ---- verilog/hdrbg_top.sv ----
// Overview of operation
// - The generator state is seeded only from the physical entropy source.
// - Each random result is handed out as one 32-bit word.
// - A reseed request refreshes the state before any further output.
// - A 128-bit counter in the state keeps 128-bit outputs from repeating.
// - A stuck-source check runs from start and any failure blocks output.
// - A total failure discards all output derived from later raw bits.
// - A windowed ones-count test runs at start-up and throughout operation.
// - Output is withheld until start-up test passes and after any defect.
`include "hdrbg_cfg.svh"
module hdrbg_top #(
	parameter int FIFO_DEPTH = `HDRBG_FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic restart,
	input wire logic raw_valid,
	input wire logic raw_bit,
	input wire logic reseed_req,
	output logic rnd_valid,
	input wire logic rnd_ready,
	output logic [31:0] rnd_data,
	output logic reseed_busy,
	output logic fail_flag
);
	hdrbg_pkg::hdrbg_state_e state_r;
	hdrbg_pkg::hdrbg_state_e state_nxt;
	hdrbg_pkg::hdrbg_health_s health;
	logic [127:0] key_r;
	logic [127:0] ctr_r;
	logic [127:0] seed_r;
	logic [7:0] seed_cnt_r;
	logic [1:0] lane_r;
	logic pend_reseed_r;
	logic failed;
	logic gen_valid;
	logic gen_ready;
	logic [31:0] gen_word;
	logic [31:0] mix_word;
	logic seed_done;
	logic f_valid;
	logic [31:0] f_data;
	logic flush;

	function automatic logic [31:0] hdrbg_mix(input logic [31:0] a,
		input logic [31:0] b);
		logic [31:0] t;
		t = a ^ {b[18:0], b[31:19]};
		hdrbg_mix = (t + `HDRBG_MIX_CONST) ^ {t[6:0], t[31:7]};
	endfunction

	// ==========================================
	// Health and control
	hdrbg_health u_health (
		.mclk(mclk),
		.resetn(resetn),
		.ce(ce),
		.restart(restart),
		.raw_valid(raw_valid),
		.raw_bit(raw_bit),
		.health(health)
	);
	assign failed = health.stuck_fail || health.online_fail;
	assign seed_done = raw_valid && seed_cnt_r == `HDRBG_SEED_BITS - 8'h01;
	assign flush = failed || state_r != hdrbg_pkg::HDRBG_RUN
		|| reseed_req || pend_reseed_r || restart;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
		hdrbg_pkg::HDRBG_IDLE:
			state_nxt = hdrbg_pkg::HDRBG_STARTUP;
		hdrbg_pkg::HDRBG_STARTUP:
			if (health.startup_ok)
				state_nxt = hdrbg_pkg::HDRBG_SEEDING;
		hdrbg_pkg::HDRBG_SEEDING:
			if (seed_done)
				state_nxt = hdrbg_pkg::HDRBG_RUN;
		hdrbg_pkg::HDRBG_RUN:
			if (pend_reseed_r || reseed_req)
				state_nxt = hdrbg_pkg::HDRBG_SEEDING;
		default:
			state_nxt = state_r;
		endcase
		if (failed)
			state_nxt = hdrbg_pkg::HDRBG_FAILED;
		if (restart)
			state_nxt = hdrbg_pkg::HDRBG_IDLE;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			state_r <= hdrbg_pkg::HDRBG_IDLE;
		else if (ce)
			state_r <= state_nxt;
	end

	// ==========================================
	// Seed collection
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			seed_r <= `HDRBG_STATE_RESET;
			seed_cnt_r <= 8'h00;
			pend_reseed_r <= 1'b0;
		end else if (ce) begin
			if (state_r == hdrbg_pkg::HDRBG_SEEDING && raw_valid) begin
				seed_r <= {seed_r[126:0], raw_bit};
				seed_cnt_r <= seed_done ? 8'h00 : seed_cnt_r + 8'h01;
			end else if (state_r != hdrbg_pkg::HDRBG_SEEDING) begin
				seed_cnt_r <= 8'h00;
			end
			if (reseed_req && state_r != hdrbg_pkg::HDRBG_RUN)
				pend_reseed_r <= 1'b1;
			else if (state_r == hdrbg_pkg::HDRBG_SEEDING)
				pend_reseed_r <= 1'b0;
		end
	end

	// ==========================================
	// Generator core
	assign gen_valid = state_r == hdrbg_pkg::HDRBG_RUN && !failed
		&& !reseed_req && !pend_reseed_r;
	assign mix_word = hdrbg_mix(key_r[lane_r*32 +: 32],
		ctr_r[lane_r*32 +: 32]);
	assign gen_word = mix_word ^ key_r[127-lane_r*32 -: 32];

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			key_r <= `HDRBG_STATE_RESET;
			ctr_r <= `HDRBG_STATE_RESET;
			lane_r <= 2'b00;
		end else if (ce) begin
			if (state_r == hdrbg_pkg::HDRBG_SEEDING && seed_done) begin
				key_r <= key_r ^ {seed_r[126:0], raw_bit};
				lane_r <= 2'b00;
			end else if (gen_valid && gen_ready) begin
				lane_r <= lane_r + 2'b01;
				if (lane_r == 2'b11)
					ctr_r <= ctr_r + 128'h1;
			end
		end
	end

	// ==========================================
	// Output buffer
	hdrbg_fifo_mem #(
		.WIDTH(32),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.resetn(resetn),
		.ce(ce),
		.flush(flush),
		.in_valid(gen_valid),
		.in_ready(gen_ready),
		.in_data(gen_word),
		.out_valid(f_valid),
		.out_ready(rnd_ready && rnd_valid || !rnd_valid),
		.out_data(f_data)
	);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rnd_valid <= 1'b0;
			rnd_data <= 32'h00000000;
			reseed_busy <= 1'b0;
			fail_flag <= 1'b0;
		end else if (ce) begin
			if (flush) begin
				rnd_valid <= 1'b0;
				rnd_data <= 32'h00000000;
			end else if (!rnd_valid || rnd_ready) begin
				rnd_valid <= f_valid;
				rnd_data <= f_data;
			end
			reseed_busy <= state_nxt == hdrbg_pkg::HDRBG_SEEDING;
			fail_flag <= failed && !restart;
		end
	end
endmodule // hdrbg_top

// ---- sim/hdrbg_top_assertions.sv ----
module hdrbg_top_assertions (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic restart,
	input wire logic raw_valid,
	input wire logic raw_bit,
	input wire logic reseed_req,
	input wire logic rnd_valid,
	input wire logic rnd_ready,
	input wire logic [31:0] rnd_data,
	input wire logic reseed_busy,
	input wire logic fail_flag
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// Raw bit counters
	logic [10:0] bits_r;
	logic [7:0] seed_r;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bits_r <= 11'h000;
			seed_r <= 8'h00;
		end else if (ce) begin
			if (restart)
				bits_r <= 11'h000;
			else if (raw_valid && bits_r != 11'h7FF)
				bits_r <= bits_r + 11'h001;
			if (!reseed_busy)
				seed_r <= 8'h00;
			else if (raw_valid && seed_r != 8'hFF)
				seed_r <= seed_r + 8'h01;
		end
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	a_fail_blocks: assert property (fail_flag |=> !rnd_valid)
		else $error("word valid while failed");
	a_fail_hold: assert property (
		ce && fail_flag && !restart |=> fail_flag)
		else $error("fail flag dropped");
	a_restart_clear: assert property (ce && restart |=> !fail_flag)
		else $error("fail flag not cleared");
	a_busy_blocks: assert property (reseed_busy |-> !rnd_valid)
		else $error("word valid while seeding");
	a_reseed_start: assert property (
		ce && reseed_req && rnd_valid && !fail_flag && !restart
		|-> ##[1:2] reseed_busy)
		else $error("reseed not started");
	a_seed_len: assert property (
		$fell(reseed_busy) && !fail_flag && !$past(restart)
		|-> seed_r == 8'h80)
		else $error("seed length wrong");
	a_start_gate: assert property (rnd_valid |-> bits_r >= 11'h480)
		else $error("word before start-up");
	a_data_hold: assert property (
		rnd_valid && !rnd_ready |=> !rnd_valid || $stable(rnd_data))
		else $error("word changed while held");
endmodule // hdrbg_top_assertions

bind hdrbg_top hdrbg_top_assertions u_chk (.mclk(mclk), .resetn(resetn),
	.ce(ce), .restart(restart), .raw_valid(raw_valid), .raw_bit(raw_bit),
	.reseed_req(reseed_req), .rnd_valid(rnd_valid), .rnd_ready(rnd_ready),
	.rnd_data(rnd_data), .reseed_busy(reseed_busy), .fail_flag(fail_flag));

// ---- sim/hdrbg_top_tb.sv ----
module hdrbg_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk, resetn, ce, restart, raw_valid, raw_bit, reseed_req, rnd_ready;
	logic rnd_valid, reseed_busy, fail_flag;
	logic [31:0] rnd_data, last_w;
	logic [16:0] seed_r;
	int bad_count, checked;
	hdrbg_top u_dut (.mclk(mclk), .resetn(resetn), .ce(ce),
		.restart(restart), .raw_valid(raw_valid), .raw_bit(raw_bit),
		.reseed_req(reseed_req), .rnd_valid(rnd_valid), .rnd_ready(rnd_ready),
		.rnd_data(rnd_data), .reseed_busy(reseed_busy), .fail_flag(fail_flag));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	task automatic chk(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic chk_word(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	// Mode 0 random, 1 stuck ones, 2 pattern 1110
	task automatic feed(input int n, input int mode, input bit stop);
		for (int i = 0; i < n; i++) begin
			@(negedge mclk);
			if (stop && rnd_valid === 1'b1)
				break;
			seed_r = lfsr(seed_r);
			raw_valid = 1'b1;
			raw_bit = mode == 0 ? seed_r[0] : (mode == 1 || i % 4 != 3);
		end
		@(negedge mclk);
		raw_valid = 1'b0;
	endtask
	task automatic pulse(ref logic s);
		@(negedge mclk);
		s = 1'b1;
		@(negedge mclk);
		s = 1'b0;
	endtask
	task automatic read_words(input int n);
		int k;
		k = 0;
		for (int i = 0; i < 200 && k < n; i++) begin
			@(negedge mclk);
			seed_r = lfsr(seed_r);
			rnd_ready = seed_r[0] | seed_r[1];
			if (rnd_ready && rnd_valid === 1'b1) begin
				chk("word changes", 1'b1, rnd_data !== last_w);
				last_w = rnd_data;
				k++;
			end
		end
		@(negedge mclk);
		rnd_ready = 1'b0;
		chk("words read", 1'b1, k == n);
	endtask
	task automatic test_done;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#60us;
		bad_count++;
		test_done;
	end
	initial begin
		{resetn, restart, raw_valid, raw_bit, reseed_req, rnd_ready} = 6'h00;
		ce = 1'b1;
		seed_r = 17'h10D6B;
		last_w = 32'h00000000;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		resetn = 1'b1;
		feed(1000, 0, 0);
		chk("valid early", 1'b0, rnd_valid);
		feed(600, 0, 1);
		chk("valid after start", 1'b1, rnd_valid);
		read_words(12);
		$display("test startup done");
		pulse(reseed_req);
		chk("busy", 1'b1, reseed_busy);
		chk("valid in reseed", 1'b0, rnd_valid);
		feed(300, 0, 1);
		chk("valid after reseed", 1'b1, rnd_valid);
		read_words(4);
		$display("test reseed done");
		// Clock enable low freezes state, outputs and health tests
		@(negedge mclk);
		chk("valid before freeze", 1'b1, rnd_valid);
		last_w = rnd_data;
		ce = 1'b0;
		reseed_req = 1'b1;
		rnd_ready = 1'b1;
		feed(40, 1, 0);
		chk("frozen valid", 1'b1, rnd_valid);
		chk_word("frozen word", last_w, rnd_data);
		chk("frozen busy", 1'b0, reseed_busy);
		ce = 1'b1;
		reseed_req = 1'b0;
		rnd_ready = 1'b0;
		@(negedge mclk);
		chk("no fail while frozen", 1'b0, fail_flag);
		$display("test freeze done");
		feed(40, 1, 0);
		chk("stuck fail", 1'b1, fail_flag);
		chk("valid stuck", 1'b0, rnd_valid);
		feed(200, 0, 0);
		chk("fail held", 1'b1, fail_flag);
		$display("test stuck done");
		pulse(restart);
		chk("fail cleared", 1'b0, fail_flag);
		feed(1200, 2, 0);
		chk("online fail", 1'b1, fail_flag);
		chk("valid online", 1'b0, rnd_valid);
		$display("test online done");
		test_done;
	end
endmodule // hdrbg_top_tb
